// *** rtl/debug_fifo.v ***
/*
 * small flip-flop fifo with valid/ready on both sides.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/10ps
module debug_fifo #(
    parameter W  = 16,
    parameter D  = 16,
    parameter AW = 4
) (
    input  wire         ref_clk,
    input  wire         rst_n,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    output wire [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready
);
    reg [W-1:0] mem_r [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0]   cnt_r;
    wire         push;
    wire         pop;

    assign in_ready  = (cnt_r != D);
    assign out_valid = (cnt_r != 0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage write
    always @(posedge ref_clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // pointers and fill count
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop)  rp_r <= rp_r + 1'b1;
            if (push && !pop) cnt_r <= cnt_r + 1'b1;
            else if (pop && !push) cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // debug_fifo

// *** rtl/debug_port_consts.vh ***
/*
 * constants for the single wire debug port: opcodes, bit timing,
 * time-out and cycle steal limits, debug map addresses.
 * assumes inclusion by bare name from the design files.
 */
`ifndef DEBUG_PORT_CONSTS_VH
`define DEBUG_PORT_CONSTS_VH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define OP_ENTER_DEBUG       8'h90
`define OP_READ_INMAP_BYTE   8'he4
`define OP_READ_INMAP_WORD   8'hec
`define OP_READ_BYTE         8'he0
`define OP_READ_WORD         8'he8
`define OP_WRITE_INMAP_BYTE  8'hc4
`define OP_WRITE_INMAP_WORD  8'hcc
`define OP_WRITE_BYTE        8'hc0
`define OP_WRITE_WORD        8'hc8

// ----------------------------------------------------------------
// bit timing in debug clock cycles
// ----------------------------------------------------------------
`define BIT_SAMPLE_CYC       10'd10
`define BIT_PULSE1_CYC       10'd7
`define BIT_LOW0_CYC         10'd13
`define BIT_PERIOD_CYC       10'd16
`define TIMEOUT_CYC          10'd512
`define STEAL_WAIT_CYC       8'd128
`define RESUME_DELAY_CYC     4'd8

// ----------------------------------------------------------------
// debug map
// ----------------------------------------------------------------
`define MAP_BASE_HI          8'hff
`define REG_STATUS_ADDR      16'hff01
`define REG_LAST_ADDR        16'hff06
`define STATUS_FW_EN_BIT     7
`define FIFO_DEPTH           16
`define FIFO_AW              4

`endif

// *** rtl/single_wire_debug_port.v ***
/*
 * single wire background debug port: serial bit engine, hardware
 * command decoder, bus cycle steal, background mode control.
 * assumes an asynchronous host on the wire and a processor bus
 * that flags free cycles and honours a freeze request.
 */
`timescale 1ns/10ps
`include "debug_port_consts.vh"
module single_wire_debug_port (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        debug_wire_in,
    output reg         debug_wire_out,
    output reg         debug_wire_oe,
    input  wire        special_single_chip,
    input  wire        bus_free,
    output reg         bus_freeze,
    output reg         bus_req,
    output reg         bus_we,
    output reg  [15:0] bus_addr,
    output reg  [15:0] bus_wdata,
    output reg  [1:0]  bus_lane,
    output reg         debug_map_en,
    input  wire [15:0] bus_rdata,
    input  wire        instr_boundary,
    input  wire        tag_hit,
    input  wire        enter_debug_instruction,
    input  wire        resume_user,
    output wire        background_active,
    output wire        firmware_debug_enable,
    output reg         exec_hold,
    output wire [15:0] rx_word,
    output wire        rx_word_valid,
    input  wire        rx_word_ready
);
    // ------------------------------------------------------------
    // wire synchroniser and edge detect
    // ------------------------------------------------------------
    reg        sync1_r;
    reg        sync2_r;
    reg        prev_r;
    wire       fall;

    // two flops before any use
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r  <= 1'b1;
        end else begin
            sync1_r <= debug_wire_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end
    // the edge itself is qualified further down: while the target
    // drives a zero, its own low would otherwise look like a new bit

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    localparam S_OP    = 3'd0;
    localparam S_ADDR  = 3'd1;
    localparam S_WDATA = 3'd2;
    localparam S_ACC   = 3'd3;
    localparam S_RDATA = 3'd4;

    reg  [2:0]  st_r;
    reg  [9:0]  bcnt_r;        // cycles since perceived bit start
    reg  [9:0]  idle_r;        // cycles since last falling edge
    reg         in_bit_r;
    reg  [4:0]  nbits_r;
    reg  [15:0] shift_r;
    reg  [7:0]  cmd_r;
    reg  [15:0] tx_r;
    reg  [7:0]  wait_r;
    reg         fw_en_r;
    reg         active_r;
    reg         enter_pend_r;
    reg  [3:0]  resume_r;
    reg         strap_done_r;
    reg         tx_bit_r;
    wire        sample;
    wire        cmd_read;
    wire        cmd_write;
    wire        cmd_inmap;
    wire        cmd_word;
    wire        fifo_ready;
    wire        in_dbg_range;
    wire        acc_go;
    wire        own_drive;
    wire        map_top;
    wire        reg_hit;

    assign sample    = in_bit_r && (bcnt_r == `BIT_SAMPLE_CYC);
    assign cmd_read  = (cmd_r[7:5] == 3'b111);
    assign cmd_write = (cmd_r[7:5] == 3'b110);
    assign cmd_inmap = cmd_r[2];
    assign cmd_word  = cmd_r[3];
    assign background_active     = active_r;
    assign firmware_debug_enable = fw_en_r;
    assign in_dbg_range = (bus_addr >= `REG_STATUS_ADDR - 16'h0001)
                          && (bus_addr <= `REG_LAST_ADDR);
    // a free bus cycle is taken at once; after the wait runs out the
    // processor is frozen for one stolen cycle instead
    assign acc_go = bus_free | (wait_r >= `STEAL_WAIT_CYC);

    // own zero drive masks edge detection for the rest of the bit
    assign own_drive = (st_r == S_RDATA) && in_bit_r;
    assign fall      = prev_r & ~sync2_r & ~own_drive;

    // debug rom and registers sit in the top page while active
    assign map_top = active_r && (bus_addr[15:8] == `MAP_BASE_HI);
    assign reg_hit = active_r && in_dbg_range;

    // ------------------------------------------------------------
    // bit timing and time-out
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_r   <= 10'd0;
            idle_r   <= 10'd0;
            in_bit_r <= 1'b0;
        end else begin
            if (fall) begin
                bcnt_r   <= 10'd0;
                idle_r   <= 10'd0;
                in_bit_r <= 1'b1;
            end else begin
                if (idle_r != `TIMEOUT_CYC) idle_r <= idle_r + 10'd1;
                if (in_bit_r) bcnt_r <= bcnt_r + 10'd1;
                if (bcnt_r == `BIT_PERIOD_CYC) in_bit_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit drive: one pulse at 7, zero low to 13 then high
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            debug_wire_out <= 1'b1;
            debug_wire_oe  <= 1'b0;
        end else if (st_r == S_RDATA && in_bit_r) begin
            if (tx_bit_r) begin
                debug_wire_out <= 1'b1;
                debug_wire_oe  <= (bcnt_r == `BIT_PULSE1_CYC);
            end else if (bcnt_r < `BIT_LOW0_CYC) begin
                debug_wire_out <= 1'b0;
                debug_wire_oe  <= 1'b1;
            end else begin
                debug_wire_out <= 1'b1;
                debug_wire_oe  <= (bcnt_r == `BIT_LOW0_CYC);
            end
        end else begin
            debug_wire_out <= 1'b1;
            debug_wire_oe  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // command engine
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r         <= S_OP;
            nbits_r      <= 5'd0;
            shift_r      <= 16'h0000;
            cmd_r        <= 8'h00;
            tx_r         <= 16'h0000;
            tx_bit_r     <= 1'b1;
            wait_r       <= 8'h00;
            bus_req      <= 1'b0;
            bus_we       <= 1'b0;
            bus_addr     <= 16'h0000;
            bus_wdata    <= 16'h0000;
            bus_lane     <= 2'b00;
            bus_freeze   <= 1'b0;
            debug_map_en <= 1'b0;
            fw_en_r      <= 1'b0;
            enter_pend_r <= 1'b0;
        end else if (idle_r == `TIMEOUT_CYC && st_r != S_ACC) begin
            st_r    <= S_OP;
            cmd_r   <= 8'h00;
            nbits_r <= 5'd0;
            // no access is open here, so drop its strobes as well
            bus_req      <= 1'b0;
            bus_freeze   <= 1'b0;
            debug_map_en <= 1'b0;
        end else begin
            bus_req      <= 1'b0;
            bus_freeze   <= 1'b0;
            debug_map_en <= 1'b0;
            if (strap_done_r == 1'b0 && special_single_chip) begin
                fw_en_r <= 1'b1;
            end
            if (active_r || resume_r != 4'd0) enter_pend_r <= 1'b0;
            case (st_r)
            S_OP: begin
                if (sample && fifo_ready) begin
                    shift_r <= {shift_r[14:0], sync2_r};
                    nbits_r <= nbits_r + 5'd1;
                    if (nbits_r == 5'd7) begin
                        nbits_r <= 5'd0;
                        cmd_r   <= {shift_r[6:0], sync2_r};
                        if ({shift_r[6:0], sync2_r} == `OP_ENTER_DEBUG) begin
                            enter_pend_r <= 1'b1;
                        end else if (shift_r[6:5] == 2'b11) begin
                            st_r <= S_ADDR;
                        end
                    end
                end
            end
            S_ADDR: begin
                if (sample && fifo_ready) begin
                    shift_r <= {shift_r[14:0], sync2_r};
                    nbits_r <= nbits_r + 5'd1;
                    if (nbits_r == 5'd15) begin
                        nbits_r  <= 5'd0;
                        bus_addr <= {shift_r[14:0], sync2_r};
                        wait_r   <= 8'h00;
                        st_r     <= cmd_read ? S_ACC : S_WDATA;
                    end
                end
            end
            S_WDATA: begin
                if (sample && fifo_ready) begin
                    shift_r <= {shift_r[14:0], sync2_r};
                    nbits_r <= nbits_r + 5'd1;
                    if (nbits_r == 5'd15) begin
                        nbits_r   <= 5'd0;
                        bus_wdata <= {shift_r[14:0], sync2_r};
                        wait_r    <= 8'h00;
                        st_r      <= S_ACC;
                    end
                end
            end
            S_ACC: begin
                if (wait_r != 8'hff) wait_r <= wait_r + 8'h01;
                if (acc_go) begin
                    bus_req    <= 1'b1;
                    bus_freeze <= ~bus_free;
                    bus_we     <= cmd_write;
                    // in-map commands map the debug area only for this
                    // cycle; while active the top page is mapped anyway
                    debug_map_en <= cmd_inmap | map_top;
                    // odd address low byte, even high, words both
                    bus_lane <= cmd_word ? 2'b11 :
                                (bus_addr[0] ? 2'b01 : 2'b10);
                    if (cmd_write && cmd_inmap && !cmd_word &&
                        bus_addr == `REG_STATUS_ADDR) begin
                        fw_en_r <= bus_wdata[`STATUS_FW_EN_BIT];
                    end
                    if (cmd_read) begin
                        tx_r <= ((cmd_inmap || reg_hit) && !cmd_word &&
                                 bus_addr == `REG_STATUS_ADDR) ?
                                {8'h00, fw_en_r, active_r, 6'h00} :
                                bus_rdata;
                        nbits_r  <= 5'd0;
                        // idle as a one: no drive before the first read bit
                        tx_bit_r <= 1'b1;
                        st_r     <= S_RDATA;
                    end else begin
                        st_r <= S_OP;
                    end
                end
            end
            S_RDATA: begin
                if (fall) begin
                    tx_bit_r <= tx_r[15];
                end
                if (sample) begin
                    tx_r    <= {tx_r[14:0], 1'b0};
                    nbits_r <= nbits_r + 5'd1;
                end
                // leave only once the last bit time has run out, so a
                // final zero is still held low for its full length
                if (nbits_r == 5'd16 && !in_bit_r) begin
                    nbits_r <= 5'd0;
                    st_r    <= S_OP;
                end
            end
            default: st_r <= S_OP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // background mode activation
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_r     <= 1'b0;
            resume_r     <= 4'd0;
            exec_hold    <= 1'b0;
            strap_done_r <= 1'b0;
        end else begin
            strap_done_r <= 1'b1;
            if (!strap_done_r && special_single_chip) begin
                active_r <= 1'b1;
            end else if (active_r) begin
                if (resume_user) active_r <= 1'b0;
            end else if (resume_r != 4'd0) begin
                resume_r  <= resume_r - 4'd1;
                exec_hold <= (resume_r != 4'd1);
            end else if (tag_hit || enter_debug_instruction ||
                         (enter_pend_r && instr_boundary)) begin
                if (fw_en_r) begin
                    active_r  <= 1'b1;
                    exec_hold <= 1'b0;
                end else begin
                    resume_r  <= `RESUME_DELAY_CYC;
                    exec_hold <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // received words to the debug firmware side
    // ------------------------------------------------------------
    reg         rxv_r;
    reg  [15:0] rxd_r;

    // completed address or data words are queued for firmware
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxv_r <= 1'b0;
            rxd_r <= 16'h0000;
        end else begin
            rxv_r <= sample && fifo_ready && nbits_r == 5'd15 &&
                     (st_r == S_ADDR || st_r == S_WDATA);
            rxd_r <= {shift_r[14:0], sync2_r};
        end
    end

    debug_fifo #(
        .W  (16),
        .D  (`FIFO_DEPTH),
        .AW (`FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_data   (rxd_r),
        .in_valid  (rxv_r),
        .in_ready  (fifo_ready),
        .out_data  (rx_word),
        .out_valid (rx_word_valid),
        .out_ready (rx_word_ready)
    );
endmodule // single_wire_debug_port

// *** test/single_wire_debug_port_chk.sv ***
/* checker for the single wire debug port outputs.
   assumes binding to every single_wire_debug_port instance. */
`timescale 1ns/10ps
module single_wire_debug_port_chk (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       debug_wire_out,
    input wire logic       debug_wire_oe,
    input wire logic       bus_free,
    input wire logic       bus_freeze,
    input wire logic       bus_req,
    input wire logic [1:0] bus_lane,
    input wire logic       debug_map_en,
    input wire logic       tag_hit,
    input wire logic       resume_user,
    input wire logic       background_active,
    input wire logic       firmware_debug_enable,
    input wire logic       exec_hold
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // refused activation: eight held cycles then release
    sequence hold8_s;
        exec_hold [*8] ##1 !exec_hold;
    endsequence
    // zero bit: wire kept low by the target
    sequence zero_low_s;
        (debug_wire_oe && !debug_wire_out) [*8];
    endsequence

    req_pulse_a: assert property (bus_req |=> !bus_req)
        else $error("access request longer than one cycle");
    map_in_req_a: assert property (debug_map_en |-> bus_req)
        else $error("debug map enabled outside access");
    lane_valid_a: assert property (bus_req |-> bus_lane != 2'b00)
        else $error("access without byte lane");
    steal_req_a: assert property ($rose(bus_freeze) |-> ##[0:2] bus_req)
        else $error("freeze without stolen access");
    free_cycle_a: assert property (bus_req |->
        $past(bus_free) || bus_freeze || $past(bus_freeze))
        else $error("access in a busy cycle");
    bg_enable_a: assert property ($rose(background_active) |->
        firmware_debug_enable)
        else $error("background entered while disabled");
    bg_stays_a: assert property (background_active && !resume_user
        |=> background_active)
        else $error("background dropped without resume");
    refuse_hold_a: assert property ($rose(exec_hold) |-> hold8_s)
        else $error("refusal hold not eight cycles");
    refuse_nobg_a: assert property (exec_hold |-> !background_active)
        else $error("background during refusal hold");
    tag_enter_a: assert property (firmware_debug_enable && tag_hit
        && !resume_user |=> background_active)
        else $error("tag did not enter background");
    zero_low_a: assert property ($rose(debug_wire_oe) && !debug_wire_out
        |-> zero_low_s)
        else $error("zero bit low too short");
    one_pulse_a: assert property ($rose(debug_wire_oe) && debug_wire_out
        |-> ##[1:3] !debug_wire_oe)
        else $error("speed-up pulse not brief");
endmodule // single_wire_debug_port_chk

bind single_wire_debug_port single_wire_debug_port_chk u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .debug_wire_out(debug_wire_out),
    .debug_wire_oe(debug_wire_oe), .bus_free(bus_free),
    .bus_freeze(bus_freeze), .bus_req(bus_req), .bus_lane(bus_lane),
    .debug_map_en(debug_map_en), .tag_hit(tag_hit),
    .resume_user(resume_user), .background_active(background_active),
    .firmware_debug_enable(firmware_debug_enable), .exec_hold(exec_hold));

// *** test/single_wire_debug_port_tb.sv ***
/* self-checking bench for the single wire debug port.
   assumes the host model and the bound checker are compiled. */
`timescale 1ns/10ps
module single_wire_debug_port_tb;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ssc = 1'b0;
    logic        bus_free = 1'b1;
    logic [3:0]  ev = 4'h0;
    logic        rx_rdy = 1'b1;
    logic        host_low;
    wire         wire_lvl, oe, wo, frz, req, we, map, bg, en, hold, rxv;
    wire  [15:0] addr, wdata, rdata, rxw;
    wire  [1:0]  lane;
    logic [35:0] cap;
    logic [15:0] d;
    logic [15:0] rxq[$];
    int          n_frz = 0;
    int          fail_count = 0;
    int          checks_done = 0;
    logic [7:0]  wr_op[4] = '{8'hc0, 8'hc8, 8'hc4, 8'hcc};
    logic [7:0]  rd_op[4] = '{8'he0, 8'he8, 8'he4, 8'hec};
    logic [15:0] ad[4] = '{16'h3001, 16'h1234, 16'h2002, 16'h2004};
    logic [1:0]  ln[4] = '{2'h1, 2'h3, 2'h2, 2'h3};

    // ----------------------------------------
    // clock, wire, memory and monitors
    // ----------------------------------------
    always #2.5 ref_clk = ~ref_clk;
    // pull-up wins when nobody drives
    assign wire_lvl = host_low ? 1'b0 : (oe ? wo : 1'b1);
    assign rdata = addr ^ 16'h5a5a;

    single_wire_debug_port i_single_wire_debug_port (
        .ref_clk(ref_clk), .rst_n(rst_n), .debug_wire_in(wire_lvl),
        .debug_wire_out(wo), .debug_wire_oe(oe),
        .special_single_chip(ssc), .bus_free(bus_free),
        .bus_freeze(frz), .bus_req(req), .bus_we(we), .bus_addr(addr),
        .bus_wdata(wdata), .bus_lane(lane), .debug_map_en(map),
        .bus_rdata(rdata), .instr_boundary(ev[0]), .tag_hit(ev[1]),
        .enter_debug_instruction(ev[2]), .resume_user(ev[3]),
        .background_active(bg), .firmware_debug_enable(en),
        .exec_hold(hold), .rx_word(rxw), .rx_word_valid(rxv),
        .rx_word_ready(rx_rdy));
    swdp_host host (.ref_clk(ref_clk), .debug_wire(wire_lvl),
                    .host_low(host_low));

    // capture each access and each fifo word
    always @(posedge ref_clk) begin
        if (req) cap <= {we, map, lane, addr, wdata};
        if (frz) n_frz <= n_frz + 1;
        if (rxv && rx_rdy) rxq.push_back(rxw);
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task chk(input string nm, input logic [35:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task pulse(input int k);
        @(posedge ref_clk) ev[k] <= 1'b1;
        @(posedge ref_clk) ev[k] <= 1'b0;
    endtask
    task do_reset(input logic s);
        @(posedge ref_clk) rst_n <= 1'b0;
        ssc <= s;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        settle(3);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_writes;
        for (int i = 0; i < 4; i++) begin
            host.write_cmd(wr_op[i], ad[i], 16'hbe00 + 16'(i));
            chk("wr cap", cap, {1'b1, i[1], ln[i], ad[i], 16'hbe00 + 16'(i)});
            chk("wr addr word", rxq[$-1], ad[i]);
            chk("wr data word", rxq[$], 16'hbe00 + 16'(i));
        end
    endtask
    task t_reads;
        logic [15:0] e;
        for (int i = 0; i < 4; i++) begin
            host.read_cmd(rd_op[i], ad[i], d);
            e = ad[i] ^ 16'h5a5a;
            chk("rd cap", cap[35:16], {1'b0, i[1], ln[i], ad[i]});
            if (ln[i] == 2'h1) chk("rd low", d[7:0], e[7:0]);
            else if (ln[i] == 2'h2) chk("rd high", d[15:8], e[15:8]);
            else chk("rd word", d, e);
        end
    endtask
    task t_steal;
        int f;
        f = n_frz;
        @(posedge ref_clk) bus_free <= 1'b0;
        host.write_cmd(8'hc8, 16'h4000, 16'h0f0f);
        chk("steal cap", cap, {4'hb, 16'h4000, 16'h0f0f});
        chk("freeze seen", n_frz > f, 1'b1);
        bus_free <= 1'b1;
    endtask
    task t_refuse;
        host.send8(8'h90);
        pulse(0);
        settle(12);
        chk("no bg cmd", bg, 1'b0);
        pulse(2);
        settle(1);
        chk("hold on", hold, 1'b1);
        settle(12);
        chk("hold off", {hold, bg}, 2'b00);
    endtask
    task t_enable;
        host.write_cmd(8'hc4, 16'hff01, 16'h0080);
        chk("fw enable", en, 1'b1);
        host.read_cmd(8'he4, 16'hff01, d);
        chk("status en", d[7], 1'b1);
        host.send8(8'h90);
        settle(8);
        chk("wait boundary", bg, 1'b0);
        pulse(0);
        settle(1);
        chk("bg on cmd", bg, 1'b1);
        for (int k = 1; k < 3; k++) begin
            pulse(3);
            settle(1);
            chk("bg off", bg, 1'b0);
            pulse(k);
            settle(1);
            chk("bg on", bg, 1'b1);
        end
    endtask
    task t_timeout;
        for (int i = 0; i < 4; i++) host.tx_bit(1'b1);
        repeat (600) @(posedge ref_clk);
        host.write_cmd(8'hc8, 16'h5678, 16'h9abc);
        chk("after timeout", cap, {4'hb, 16'h5678, 16'h9abc});
    endtask
    task t_stall;
        @(posedge ref_clk) rx_rdy <= 1'b0;
        host.write_cmd(8'hc8, 16'h6000, 16'h1111);
        chk("stall head", {rxv, rxw}, {1'b1, 16'h6000});
        @(posedge ref_clk) rx_rdy <= 1'b1;
        settle(3);
        chk("drained", rxv, 1'b0);
        chk("last word", rxq[$], 16'h1111);
    endtask

    // main sequence
    initial begin
        do_reset(1'b0);
        chk("idle", {oe, wo, en, bg, hold, req}, 6'b010000);
        t_writes;
        t_reads;
        t_steal;
        t_refuse;
        t_enable;
        t_timeout;
        t_stall;
        do_reset(1'b1);
        chk("ssc state", {en, bg}, 2'b11);
        give_verdict;
    end
    // watchdog
    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        give_verdict;
    end
endmodule // single_wire_debug_port_tb

// *** test/swdp_host.sv ***
/* debug host model that starts every bit on the single wire.
   assumes the bench resolves the wire with a pull-up. */
`timescale 1ns/10ps
module swdp_host (
    input  wire logic ref_clk,
    input  wire logic debug_wire,
    output logic      host_low
);
    // ----------------------------------------
    // bit and command tasks
    // ----------------------------------------
    initial host_low = 1'b0;

    // host to target bit: short low is one, long low is zero
    task tx_bit(input logic b);
        @(posedge ref_clk) host_low <= 1'b1;
        repeat (b ? 4 : 15) @(posedge ref_clk);
        host_low <= 1'b0;
        repeat (b ? 16 : 5) @(posedge ref_clk);
    endtask
    // target to host bit: brief low, release, sample near ten
    task rx_bit(output logic b);
        @(posedge ref_clk) host_low <= 1'b1;
        repeat (2) @(posedge ref_clk);
        host_low <= 1'b0;
        repeat (10) @(posedge ref_clk);
        b = debug_wire;
        repeat (8) @(posedge ref_clk);
    endtask
    task send8(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) tx_bit(v[i]);
    endtask
    task send16(input logic [15:0] v);
        for (int i = 15; i >= 0; i--) tx_bit(v[i]);
    endtask
    task write_cmd(input logic [7:0] op, input logic [15:0] a, dat);
        send8(op);
        send16(a);
        send16(dat);
        repeat (150) @(posedge ref_clk);
    endtask
    task read_cmd(input logic [7:0] op, input logic [15:0] a,
                  output logic [15:0] dat);
        send8(op);
        send16(a);
        repeat (150) @(posedge ref_clk);
        for (int i = 15; i >= 0; i--) rx_bit(dat[i]);
    endtask
endmodule // swdp_host
